// file: hw/ipk_top.sv
// apb register block: source priorities, keyboard line enables, flags
// assumes srcReq is on clk and keyPin comes straight from pins
//
// Overview of operation
// - upper priority register at index b7h, bits 6..0 per source.
// - bit 7 of upper priority is reserved; reads zero, writes ignored.
// - a source level is its upper bit over its lower bit, 00 lowest.
// - upper priority resets to zero and is byte access only.
// - keyboard line enable register at index 9dh, bit n for line n.
// - enable clear keeps pin as I/O; set lets its flag interrupt.
// - all keyboard line enables reset to zero.
//
// Local design decision: the APB slave port.
`default_nettype none

module ipk_top
    import ipk_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ipk_pkg::AW-1:0]   paddr,
    input  wire logic [ipk_pkg::DW-1:0]   pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [ipk_pkg::DW-1:0]   prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [ipk_pkg::NSRC-1:0] srcReq,
    input  wire logic [ipk_pkg::NKEY-1:0] keyPin,
    output logic      [ipk_pkg::NKEY-1:0] keyLineIoMode,
    output logic                      kbdIrq,
    output logic                      grantValid,
    output logic      [ipk_pkg::IDW-1:0]  grantId,
    output logic      [ipk_pkg::LVLW-1:0] grantLevel
);
    import ipk_pkg::*;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rstMeta_r;
    logic rstSync_n;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_r <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_n <= rstMeta_r;
        end
    end

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic            setup;
    logic            access;
    logic            wrDone;
    logic            rdDone;
    logic            inRange;
    logic            hitKeyEn;
    logic            hitFlags;
    logic            hitUpper;
    logic            hitLower;
    logic            hit;
    logic [DW-1:0]   readMux;
    logic [DW-1:0]   prdata_r;
    logic [NKEY-1:0] rdFlags_r;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign inRange  = paddr[AW-1:10] == 2'h0;
    assign hitKeyEn = inRange && paddr[9:2] == KEYEN_IDX;
    assign hitFlags = inRange && paddr[9:2] == FLAGS_IDX;
    assign hitUpper = inRange && paddr[9:2] == UPPER_IDX;
    assign hitLower = inRange && paddr[9:2] == LOWER_IDX;
    assign hit      = hitKeyEn || hitFlags || hitUpper || hitLower;

    // zero wait states: access phase always completes
    assign pready   = access;
    assign pslverr  = access && !hit;
    assign wrDone   = access && pwrite && hit && pstrb[0];
    assign rdDone   = access && !pwrite;
    assign prdata   = prdata_r;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [NSRC-1:0] upper_r;
    logic [NSRC-1:0] lower_r;
    logic [NKEY-1:0] keyEn_r;
    logic [NKEY-1:0] flags_r;
    logic [NKEY-1:0] flags_nxt;
    logic [NKEY-1:0] keyFall;

    // only byte lane 0 carries data; no bit-address path exists
    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            upper_r <= UPPER_RST;
        end
        else if (wrDone && hitUpper)
        begin
            upper_r <= pwdata[NSRC-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            lower_r <= LOWER_RST;
        end
        else if (wrDone && hitLower)
        begin
            lower_r <= pwdata[NSRC-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            keyEn_r <= KEYEN_RST;
        end
        else if (wrDone && hitKeyEn)
        begin
            keyEn_r <= pwdata[NKEY-1:0];
        end
    end

    // read data is captured in setup so the access phase needs no wait
    always_comb
    begin
        readMux = '0;
        if (hitKeyEn)
        begin
            readMux[NKEY-1:0] = keyEn_r;
        end
        else if (hitFlags)
        begin
            readMux[NKEY-1:0] = flags_r;
        end
        else if (hitUpper)
        begin
            readMux[NSRC-1:0] = upper_r;
        end
        else if (hitLower)
        begin
            readMux[NSRC-1:0] = lower_r;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            prdata_r  <= '0;
            rdFlags_r <= '0;
        end
        else if (setup)
        begin
            prdata_r  <= pwrite ? '0 : readMux;
            rdFlags_r <= (!pwrite && hitFlags) ? flags_r : '0;
        end
    end

    // ----------------------------------------
    // keyboard pins
    // ----------------------------------------
    logic [NKEY-1:0] keyS1_r;
    logic [NKEY-1:0] keyS2_r;
    logic [NKEY-1:0] keyS3_r;
    logic [NKEY-1:0] keyStable_r;

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            keyS1_r <= KEYPIN_RST;
            keyS2_r <= KEYPIN_RST;
            keyS3_r <= KEYPIN_RST;
        end
        else
        begin
            keyS1_r <= keyPin;
            keyS2_r <= keyS1_r;
            keyS3_r <= keyS2_r;
        end
    end

    // a line changes only once two stages agree, filtering one-cycle noise
    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            keyStable_r <= KEYPIN_RST;
        end
        else
        begin
            for (int i = 0; i < NKEY; i++)
            begin
                if (keyS2_r[i] == keyS3_r[i])
                begin
                    keyStable_r[i] <= keyS3_r[i];
                end
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NKEY; i++)
        begin
            keyFall[i] = keyStable_r[i] && !keyS3_r[i] && (keyS2_r[i] == keyS3_r[i]);
        end
    end

    // ----------------------------------------
    // flags and interrupt
    // ----------------------------------------
    // a fall in the clearing read's cycle survives: set beats clear
    assign flags_nxt = (flags_r & ~(rdDone ? rdFlags_r : '0)) | keyFall;

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            flags_r <= FLAGS_RST;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    // flags always latch; the enable only gates the request
    assign kbdIrq        = |(flags_r & keyEn_r);
    assign keyLineIoMode = ~keyEn_r;

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    ipk_arb_if arbIf ();

    assign arbIf.req   = srcReq;
    assign arbIf.upper = upper_r;
    assign arbIf.lower = lower_r;

    ipk_arbiter u_arb
    (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .a         (arbIf.arb)
    );

    assign grantValid = arbIf.valid;
    assign grantId    = arbIf.id;
    assign grantLevel = arbIf.level;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_write(logic h);
        access && pwrite && pstrb[0] && h;
    endsequence

    sequence s_read(logic h);
        access && !pwrite && h;
    endsequence

    property p_upper_write;
        @(posedge clk) disable iff (!rstSync_n)
        s_write(hitUpper) |=> upper_r == $past(pwdata[NSRC-1:0]);
    endproperty
    a_upper_write: assert property (p_upper_write) else $error("upper write lost");

    property p_upper_rsvd;
        @(posedge clk) disable iff (!rstSync_n)
        s_read(hitUpper) |-> prdata[DW-1:NSRC] == '0 && prdata[NSRC-1:0] == upper_r;
    endproperty
    a_upper_rsvd: assert property (p_upper_rsvd) else $error("upper read wrong");

    property p_upper_reset;
        @(posedge clk) disable iff (!rst_n)
        !rstSync_n |=> upper_r == UPPER_RST;
    endproperty
    a_upper_reset: assert property (p_upper_reset) else $error("upper not reset");

    property p_keyen_write;
        @(posedge clk) disable iff (!rstSync_n)
        s_write(hitKeyEn) |=> keyEn_r == $past(pwdata[NKEY-1:0]);
    endproperty
    a_keyen_write: assert property (p_keyen_write) else $error("enable write lost");

    property p_key_irq;
        @(posedge clk) disable iff (!rstSync_n)
        (keyFall[0] && keyEn_r[0] && !(access && pwrite && hitKeyEn)) |=> kbdIrq [*2];
    endproperty
    a_key_irq: assert property (p_key_irq) else $error("enabled fall gave no interrupt");

    property p_key_io;
        @(posedge clk) disable iff (!rstSync_n)
        keyEn_r == '0 |-> !kbdIrq && keyLineIoMode == 8'hff;
    endproperty
    a_key_io: assert property (p_key_io) else $error("disabled line interrupted");

    property p_keyen_reset;
        @(posedge clk) disable iff (!rst_n)
        $rose(rstSync_n) |-> keyEn_r == KEYEN_RST && !kbdIrq;
    endproperty
    a_keyen_reset: assert property (p_keyen_reset) else $error("enable not reset");

    property p_flag_clear;
        @(posedge clk) disable iff (!rstSync_n)
        s_read(hitFlags && keyFall == '0) |=> (flags_r & $past(rdFlags_r)) == '0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag read did not clear");

    property p_flag_set;
        @(posedge clk) disable iff (!rstSync_n)
        keyFall != '0 |=> (flags_r & $past(keyFall)) == $past(keyFall);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("line fall did not set its flag");

    property p_lower_write;
        @(posedge clk) disable iff (!rstSync_n)
        s_write(hitLower) |=> lower_r == $past(pwdata[NSRC-1:0]);
    endproperty
    a_lower_write: assert property (p_lower_write) else $error("lower write lost");

    property p_unmapped;
        @(posedge clk) disable iff (!rstSync_n)
        s_read(!hit) |-> pslverr && prdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

endmodule : ipk_top

`default_nettype wire

// file: hw/ipk_pkg.sv
// constants, widths and register map of the interrupt priority block
// assumes a 12-bit apb byte address; word index sits in paddr[9:2]
`default_nettype none

package ipk_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NSRC  = 7;
    localparam int NKEY  = 8;
    localparam int AW    = 12;
    localparam int DW    = 32;
    localparam int IDW   = 3;
    localparam int LVLW  = 2;

    // ----------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------
    localparam logic [7:0] KEYEN_IDX = 8'h9d;
    localparam logic [7:0] FLAGS_IDX = 8'h9e;
    localparam logic [7:0] UPPER_IDX = 8'hb7;
    localparam logic [7:0] LOWER_IDX = 8'hb8;

    // ----------------------------------------
    // field layout and reset values
    // ----------------------------------------
    localparam int UPPER_RSVD_POS          = 7;
    localparam int CNT_ARRAY_POS           = 6;
    localparam int TIMER_TWO_POS           = 5;
    localparam int SERIAL_POS              = 4;
    localparam int TIMER_ONE_POS           = 3;
    localparam int EXT_ONE_POS             = 2;
    localparam int TIMER_ZERO_POS          = 1;
    localparam int EXT_ZERO_POS            = 0;
    localparam logic [NSRC-1:0] UPPER_RST  = 7'h00;
    localparam logic [NSRC-1:0] LOWER_RST  = 7'h00;
    localparam logic [NKEY-1:0] KEYEN_RST  = 8'h00;
    localparam logic [NKEY-1:0] FLAGS_RST  = 8'h00;
    localparam logic [NKEY-1:0] KEYPIN_RST = 8'hff;

endpackage : ipk_pkg

`default_nettype wire

// file: hw/ipk_arb_if.sv
// request and grant signals between register logic and the arbiter
// assumes both ends sit on the same clock
`default_nettype none

interface ipk_arb_if;
    import ipk_pkg::*;
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] upper;
    logic [NSRC-1:0] lower;
    logic            valid;
    logic [IDW-1:0]  id;
    logic [LVLW-1:0] level;

    modport arb (input req, input upper, input lower, output valid, output id, output level);
    modport ctl (output req, output upper, output lower, input valid, input id, input level);
endinterface : ipk_arb_if

`default_nettype wire

// file: hw/ipk_arbiter.sv
// picks the pending source with the highest two-bit level
// assumes requests, priorities and reset are on clk
`default_nettype none

module ipk_arbiter
(
    input  wire logic clk,
    input  wire logic rstSync_n,
    ipk_arb_if.arb    a
);
    import ipk_pkg::*;

    logic            found;
    logic [IDW-1:0]  bestId;
    logic [LVLW-1:0] bestLvl;
    logic            valid_r;
    logic [IDW-1:0]  id_r;
    logic [LVLW-1:0] level_r;
    logic [LVLW-1:0] maxLvl;
    logic [NSRC-1:0] reqQ_r;
    logic [NSRC-1:0] upperQ_r;
    logic [NSRC-1:0] lowerQ_r;

    // ----------------------------------------
    // search
    // ----------------------------------------
    // descending scan with >= lets the lowest index win a tie
    always_comb
    begin
        found   = 1'b0;
        bestId  = '0;
        bestLvl = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (a.req[i] && (!found || {a.upper[i], a.lower[i]} >= bestLvl))
            begin
                found   = 1'b1;
                bestId  = IDW'(i);
                bestLvl = {a.upper[i], a.lower[i]};
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            valid_r <= 1'b0;
            id_r    <= '0;
            level_r <= '0;
        end
        else
        begin
            valid_r <= found;
            id_r    <= bestId;
            level_r <= bestLvl;
        end
    end

    assign a.valid = valid_r;
    assign a.id    = id_r;
    assign a.level = level_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    always_comb
    begin
        maxLvl = '0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (a.req[i] && {a.upper[i], a.lower[i]} > maxLvl)
            begin
                maxLvl = {a.upper[i], a.lower[i]};
            end
        end
    end

    property p_level_max;
        @(posedge clk) disable iff (!rstSync_n)
        $past(|a.req) |-> valid_r && level_r == $past(maxLvl);
    endproperty
    a_level_max: assert property (p_level_max) else $error("grant level not highest");

    // last cycle's inputs, so the registered winner indexes what it was chosen from
    always_ff @(posedge clk)
    begin
        reqQ_r   <= a.req;
        upperQ_r <= a.upper;
        lowerQ_r <= a.lower;
    end

    property p_level_pair;
        @(posedge clk) disable iff (!rstSync_n)
        valid_r |-> level_r == {upperQ_r[id_r], lowerQ_r[id_r]} && reqQ_r[id_r];
    endproperty
    a_level_pair: assert property (p_level_pair) else $error("grant level not upper:lower pair");

    property p_no_req;
        @(posedge clk) disable iff (!rstSync_n)
        !(|a.req) |=> !valid_r;
    endproperty
    a_no_req: assert property (p_no_req) else $error("grant without request");

endmodule : ipk_arbiter

`default_nettype wire

// file: bench/ipk_far_model.sv
// far side of the block: interrupt sources of the core and the keyboard pins
// assumes the bench sets the wanted levels just after a rising edge of clk
`default_nettype none

module ipk_far_model
    import ipk_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic [ipk_pkg::NSRC-1:0] reqCmd,
    input  wire logic [ipk_pkg::NKEY-1:0] keyCmd,
    output var  logic [ipk_pkg::NSRC-1:0] srcReq,
    output var  logic [ipk_pkg::NKEY-1:0] keyPin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // source levels and pins
    // ----------------------------------------
    // pins idle high like keys at rest, so no falling change shows up after reset
    initial keyPin = 8'hff;
    initial srcReq = 7'h00;

    // requests change one edge after the bench asks, as same-clock logic would
    always @(posedge clk)
    begin
        srcReq <= reqCmd;
        keyPin <= keyCmd;
    end
endmodule : ipk_far_model

`default_nettype wire

// file: bench/ipk_top_test.sv
// self-checking bench for the priority and keyboard enable block
// assumes hw/ files and the far-side model are compiled first
`default_nettype none

module ipk_top_test import ipk_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [AW-1:0]   paddr = 12'h000;
    logic [DW-1:0]   pwdata = 32'h0;
    logic [3:0]      pstrb = 4'hf;
    logic [DW-1:0]   prdata;
    logic            pready;
    logic            pslverr;
    logic [NSRC-1:0] srcReq;
    logic [NSRC-1:0] reqCmd = 7'h00;
    logic [NKEY-1:0] keyPin;
    logic [NKEY-1:0] keyCmd = 8'hff;
    logic [NKEY-1:0] keyLineIoMode;
    logic            kbdIrq;
    logic            grantValid;
    logic [IDW-1:0]  grantId;
    logic [LVLW-1:0] grantLevel;
    logic [DW-1:0]   rd;
    logic            err;
    int              errorCnt = 0;
    int              comparisons = 0;
    // priority cases: upper, lower, requests, winner, level
    logic [7:0]      upT [5] = '{8'h00, 8'h00, 8'h60, 8'h60, 8'h60};
    logic [7:0]      loT [5] = '{8'h00, 8'h08, 8'h08, 8'h40, 8'h40};
    logic [6:0]      rqT [5] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h3f};
    logic [2:0]      idT [5] = '{3'h0, 3'h3, 3'h5, 3'h6, 3'h5};
    logic [1:0]      lvT [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};

    initial forever #50 clk = ~clk;

    ipk_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srcReq(srcReq), .keyPin(keyPin), .keyLineIoMode(keyLineIoMode),
        .kbdIrq(kbdIrq), .grantValid(grantValid), .grantId(grantId), .grantLevel(grantLevel));

    ipk_far_model far (.clk(clk), .reqCmd(reqCmd), .keyCmd(keyCmd), .srcReq(srcReq), .keyPin(keyPin));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task complete_run;
    begin
        $display("errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask : complete_run

    task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask : chk

    // one apb transfer; waits for pready at a rising edge, bounded by the watchdog
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
             output logic [31:0] rdv, output logic erv);
    begin
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask : apb

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
    begin
        apb(1'b0, KEYEN_IDX, 32'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, UPPER_IDX, 32'h0, rd, err);
        chk(rd & 32'h7f, 32'h0);
        chk(keyLineIoMode, 8'hff);
    end
    endtask : t_reset

    // bit 7 of the upper register is never written with a one
    task t_regs;
    begin
        apb(1'b1, UPPER_IDX, 32'h7f, rd, err);
        apb(1'b0, UPPER_IDX, 32'h0, rd, err);
        chk(rd[6:0], 7'h7f);
        apb(1'b1, UPPER_IDX, 32'h2a, rd, err);
        apb(1'b0, UPPER_IDX, 32'h0, rd, err);
        chk(rd[6:0], 7'h2a);
        apb(1'b1, KEYEN_IDX, 32'ha5, rd, err);
        chk(err, 1'b0);
        apb(1'b0, KEYEN_IDX, 32'h0, rd, err);
        chk(rd, 32'ha5);
        chk(keyLineIoMode, 8'h5a);
        pstrb <= 4'h0;
        apb(1'b1, KEYEN_IDX, 32'h00, rd, err);
        pstrb <= 4'hf;
        apb(1'b0, KEYEN_IDX, 32'h0, rd, err);
        chk(rd, 32'ha5);
    end
    endtask : t_regs

    // line 0 enabled, line 1 plain io
    task t_keys;
    begin
        @(posedge clk);
        keyCmd <= 8'hfe;
        repeat (8) @(negedge clk);
        chk(kbdIrq, 1'b1);
        @(posedge clk);
        keyCmd <= 8'hff;
        apb(1'b0, FLAGS_IDX, 32'h0, rd, err);
        chk(rd, 32'h01);
        @(negedge clk);
        chk(kbdIrq, 1'b0);
        @(posedge clk);
        keyCmd <= 8'hfd;
        repeat (8) @(negedge clk);
        chk(kbdIrq, 1'b0);
        @(posedge clk);
        keyCmd <= 8'hff;
        apb(1'b0, FLAGS_IDX, 32'h0, rd, err);
        chk(rd, 32'h02);
    end
    endtask : t_keys

    task t_grant;
    begin
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, UPPER_IDX, {24'h0, upT[i]}, rd, err);
            apb(1'b1, LOWER_IDX, {24'h0, loT[i]}, rd, err);
            apb(1'b0, LOWER_IDX, 32'h0, rd, err);
            chk(rd, {24'h0, loT[i]});
            @(posedge clk);
            reqCmd <= rqT[i];
            repeat (4) @(negedge clk);
            chk(grantValid, 1'b1);
            chk(grantId, idT[i]);
            chk(grantLevel, lvT[i]);
        end
        @(posedge clk);
        reqCmd <= 7'h00;
        repeat (4) @(negedge clk);
        chk(grantValid, 1'b0);
    end
    endtask : t_grant

    task t_unmapped;
    begin
        apb(1'b0, 8'h10, 32'h0, rd, err);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h10, 32'h55, rd, err);
        chk(err, 1'b1);
    end
    endtask : t_unmapped

    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset();
        t_regs();
        t_keys();
        t_grant();
        t_unmapped();
        complete_run();
    end

    // the run needs well under a thousand cycles
    initial
    begin
        #500000;
        errorCnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule : ipk_top_test

`default_nettype wire
